// file: rtl/swic_top.sv
// Sleep/wake interrupt control: control register, buffer gate, detector sleep enables and interrupt pin drive.
// Assumes the serial port decoder presents single-cycle register strobes on clk_in, and that mode, sample,
// buffer-empty and detector signals come from logic on the same clock. Interrupt pins leave the chip.
`timescale 1ns/1ps
`include "swic_params.svh"

module swic_top (
  input  wire logic                    clk_in,            // System clock, 200 MHz.
  input  wire logic                    rst_in,            // Synchronous reset, active high.
  input  wire logic [7:0]              reg_addr_in,       // Register address from the serial port.
  input  wire logic [7:0]              reg_wdata_in,      // Write data.
  input  wire logic                    reg_wr_in,         // Write strobe, one cycle.
  input  wire logic                    reg_rd_in,         // Read strobe, one cycle.
  output logic [7:0]                   reg_rdata_out,     // Read data, valid the cycle after the strobe.
  input  wire logic                    sleep_mode_in,     // System state: 1 sleep, 0 wake.
  input  wire logic                    auto_sleep_en_in,  // Auto-sleep enabled.
  input  wire logic                    sample_valid_in,   // New sample offered to the buffer.
  input  wire logic                    fifo_empty_in,     // Sample buffer is empty.
  input  wire logic [4:0]              det_event_in,      // Events: trans, orient, pulse, ffmt, vecm.
  input  wire logic                    irq_one_req_in,    // Routed interrupt for line one, active high.
  input  wire logic                    irq_two_req_in,    // Routed interrupt for line two, active high.
  input  wire swic_pkg::swic_rate_t     rate_in,           // Data-rate code.
  input  wire swic_pkg::swic_osr_mode_t osr_mode_in,       // Oversampling mode.
  input  wire logic                    irq_line_one_in,   // Level sensed on interrupt pin one.
  input  wire logic                    irq_line_two_in,   // Level sensed on interrupt pin two.
  output logic [7:0]                   ctrl_out,          // Current control register value.
  output logic                         fifo_flush_out,    // Flush the buffer, one-cycle pulse.
  output logic                         fifo_accept_out,   // Write the offered sample, one-cycle pulse.
  output logic                         fifo_held_out,     // Buffer is held by the gate.
  output logic                         fifo_gate_err_out, // Gate error flag of the state status.
  output logic [4:0]                   det_enable_out,    // Detector run enables.
  output logic                         debounce_clr_out,  // Clear detector debounce counters, pulse.
  output logic                         wake_req_out,      // Enabled event seen while asleep.
  output logic [10:0]                  osr_ratio_out,     // Oversampling ratio in use.
  output logic                         irq_line_one_out,  // Interrupt pin one output value.
  output logic                         irq_line_one_oe_n_out, // Pin one drive, low while driving.
  output logic                         irq_line_two_out,  // Interrupt pin two output value.
  output logic                         irq_line_two_oe_n_out, // Pin two drive, low while driving.
  output logic                         irq_line_one_level_out, // Synchronised level of pin one.
  output logic                         irq_line_two_level_out  // Synchronised level of pin two.
);

  // Control register and its fields.
  logic [7:0] ctrl_reg;           // Control register.
  logic [7:0] ctrl_next;          // Its next value.
  wire        gate_en;            // Gate holds buffer across mode changes.
  wire  [4:0] wake_bits;          // Per-detector sleep-wake enables.
  wire        irq_pol;            // 1 selects active-high interrupt pins.
  wire        irq_drive_type;     // 1 selects open-drain interrupt pins.
  wire        ctrl_hit;           // Address matches the control register.

  // Only the acceleration wake bits live here; magnetic wake enables sit in their own configuration
  // registers, so this register stays eight bits with no magnetic field.
  assign ctrl_hit       = (reg_addr_in == `SWIC_CTRL_ADDR);
  assign gate_en        = ctrl_reg[`SWIC_BIT_FIFO_GATE];
  assign wake_bits      = ctrl_reg[`SWIC_BIT_WAKE_HI:`SWIC_BIT_WAKE_LO];
  assign irq_pol        = ctrl_reg[`SWIC_BIT_IRQ_POL];
  assign irq_drive_type = ctrl_reg[`SWIC_BIT_IRQ_DRIVE];
  assign ctrl_next      = (reg_wr_in && ctrl_hit) ? reg_wdata_in : ctrl_reg;

  // Register write path.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_reg <= `SWIC_CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  // Read path; unmapped addresses read as zero.
  logic [7:0] rdata_reg; // Read data register.
  wire  [7:0] rdata_next;
  assign rdata_next = (reg_rd_in && ctrl_hit) ? ctrl_reg : 8'h00;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // Mode-change detection against the previous system state.
  logic sleep_prev_reg; // System state one cycle ago.
  wire  mode_edge;      // System state changed this cycle.
  assign mode_edge = (sleep_mode_in != sleep_prev_reg);

  // Resets to wake, so a block that leaves reset asleep sees one mode change.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sleep_prev_reg <= 1'b0;
    else
      sleep_prev_reg <= sleep_mode_in;
  end

  // Buffer gate state machine.
  swic_pkg::swic_gate_state_t gate_reg;  // Gate state.
  swic_pkg::swic_gate_state_t gate_next; // Next gate state.

  // A change while already holding keeps holding; the buffer still carries data from the older period.
  always_comb
  begin
    gate_next = gate_reg;
    unique case (gate_reg)
      swic_pkg::GATE_OPEN:
      begin
        if (mode_edge && gate_en && !fifo_empty_in)
          gate_next = swic_pkg::GATE_HELD;
      end
      swic_pkg::GATE_HELD:
      begin
        // Emptying the buffer is the only release; clearing the gate bit does not drop held data.
        if (fifo_empty_in)
          gate_next = swic_pkg::GATE_OPEN;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      gate_reg <= swic_pkg::GATE_OPEN;
    else
      gate_reg <= gate_next;
  end

  // Sample acceptance, flush and error decode.
  wire held_now;    // Buffer held and not yet emptied.
  wire flush_next;  // Flush request.
  wire accept_next; // Sample write request.
  wire err_next;    // Next gate error flag.
  assign held_now    = (gate_reg == swic_pkg::GATE_HELD) && !fifo_empty_in;
  assign flush_next  = mode_edge && !gate_en && !held_now;
  // A sample in the same cycle as a mode change still belongs to the old period and is refused
  // only when the gate actually holds; an empty buffer needs no protection.
  assign accept_next = sample_valid_in && !held_now &&
                       !(mode_edge && gate_en && !fifo_empty_in);
  // The set term only exists while the buffer is unemptied, so it can never meet the clear.
  assign err_next    = (held_now && sample_valid_in) ? 1'b1 :
                       fifo_empty_in                  ? 1'b0 :
                       fifo_gate_err_out;

  // Buffer control outputs, all registered.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fifo_flush_out    <= 1'b0;
      fifo_accept_out   <= 1'b0;
      fifo_held_out     <= 1'b0;
      fifo_gate_err_out <= 1'b0;
    end
    else
    begin
      fifo_flush_out    <= flush_next;
      fifo_accept_out   <= accept_next;
      fifo_held_out     <= (gate_next == swic_pkg::GATE_HELD);
      fifo_gate_err_out <= err_next;
    end
  end

  // Detector enables, wake request and debounce clear.
  wire [4:0] enable_next;   // Detector runs when awake, or asleep with its wake bit.
  wire       wake_next;     // Enabled event while asleep.
  wire       debounce_next; // Counter clear on an auto-sleep transition.
  assign enable_next   = {5{!sleep_mode_in}} | wake_bits;
  assign wake_next     = sleep_mode_in && |(det_event_in & wake_bits);
  // Only the debounce counters are cleared; event status is left alone.
  assign debounce_next = mode_edge && auto_sleep_en_in;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      det_enable_out   <= 5'h1f;
      wake_req_out     <= 1'b0;
      debounce_clr_out <= 1'b0;
    end
    else
    begin
      det_enable_out   <= enable_next;
      wake_req_out     <= wake_next;
      debounce_clr_out <= debounce_next;
    end
  end

  // Oversampling ratio lookup.
  wire [10:0] osr_next; // Looked-up ratio.

  swic_osr_lookup u_osr (
    .rate_in   (rate_in),
    .mode_in   (osr_mode_in),
    .ratio_out (osr_next)
  );

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      osr_ratio_out <= 11'h002;
    else
      osr_ratio_out <= osr_next;
  end

  // Interrupt pin drive. Open-drain can only pull low, so in that mode an asserted active-high
  // line relies on the external pull-up, and a deasserted active-low line likewise.
  // Both pins share one polarity decode, so it is kept in one place.
  function automatic logic pin_level(input logic pol, input logic req);
    pin_level = pol ? req : !req;
  endfunction

  wire one_level; // Wanted level on pin one.
  wire two_level; // Wanted level on pin two.
  assign one_level = pin_level(irq_pol, irq_one_req_in);
  assign two_level = pin_level(irq_pol, irq_two_req_in);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_line_one_out      <= 1'b1;
      irq_line_one_oe_n_out <= 1'b0;
      irq_line_two_out      <= 1'b1;
      irq_line_two_oe_n_out <= 1'b0;
    end
    else
    begin
      irq_line_one_out      <= irq_drive_type ? 1'b0 : one_level;
      irq_line_one_oe_n_out <= irq_drive_type ? one_level : 1'b0;
      irq_line_two_out      <= irq_drive_type ? 1'b0 : two_level;
      irq_line_two_oe_n_out <= irq_drive_type ? two_level : 1'b0;
    end
  end

  // Two-stage synchronisers for the sensed pin levels.
  logic [1:0] pin_meta_reg; // First stages, read only by the second.

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_meta_reg           <= 2'h3;
      irq_line_one_level_out <= 1'b1;
      irq_line_two_level_out <= 1'b1;
    end
    else
    begin
      pin_meta_reg           <= {irq_line_two_in, irq_line_one_in};
      irq_line_one_level_out <= pin_meta_reg[0];
      irq_line_two_level_out <= pin_meta_reg[1];
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign ctrl_out      = ctrl_reg;

endmodule // swic_top

// file: rtl/swic_params.svh
// Constants for the sleep/wake interrupt control block: register offset, reset value, field positions, ratios.
// Assumes it is included by bare name from the block's design and testbench files.
`ifndef SWIC_PARAMS_SVH
`define SWIC_PARAMS_SVH

`define SWIC_CTRL_ADDR      8'h2c
`define SWIC_CTRL_RESET     8'h00
`define SWIC_BIT_FIFO_GATE  7
`define SWIC_BIT_WAKE_HI    6
`define SWIC_BIT_WAKE_LO    2
`define SWIC_BIT_IRQ_POL    1
`define SWIC_BIT_IRQ_DRIVE  0

// Oversampling ratios, columns normal / low-noise low-power / high resolution / low power.
`define SWIC_OSR_1_5625     {11'h0080, 11'h0020, 11'h0400, 11'h0010}
`define SWIC_OSR_6_25       {11'h0020, 11'h0008, 11'h0100, 11'h0004}
`define SWIC_OSR_12_5       {11'h0010, 11'h0004, 11'h0080, 11'h0002}
`define SWIC_OSR_50         {11'h0004, 11'h0004, 11'h0020, 11'h0002}
`define SWIC_OSR_100        {11'h0004, 11'h0004, 11'h0010, 11'h0002}
`define SWIC_OSR_200        {11'h0004, 11'h0004, 11'h0008, 11'h0002}
`define SWIC_OSR_400        {11'h0004, 11'h0004, 11'h0004, 11'h0002}
`define SWIC_OSR_800        {11'h0002, 11'h0002, 11'h0002, 11'h0002}

`endif

// file: rtl/swic_pkg.sv
// Types shared by the sleep/wake interrupt control block.
// Assumes the constants header is compiled alongside.
package swic_pkg;

  // Buffer gate: open, or holding contents across a mode change.
  typedef enum logic [0:0] {GATE_OPEN, GATE_HELD} swic_gate_state_t;

  // Oversampling mode select.
  typedef logic [1:0] swic_osr_mode_t;

  // Data-rate code, 0 is the fastest rate and 7 the slowest.
  typedef logic [2:0] swic_rate_t;

endpackage

// file: rtl/swic_osr_lookup.sv
// Oversampling ratio lookup from data-rate code and oversampling mode.
// Assumes both selects come from logic on the same clock; the result is combinational.
`timescale 1ns/1ps
`include "swic_params.svh"

module swic_osr_lookup (
  input  wire swic_pkg::swic_rate_t     rate_in,  // Data-rate code.
  input  wire swic_pkg::swic_osr_mode_t mode_in,  // Oversampling mode.
  output logic [10:0]                   ratio_out // Selected ratio.
);

  // Picks one row of four packed ratios; column 0 of the mode sits in the top slice.
  function automatic logic [10:0] pick(input logic [43:0] row, input logic [1:0] mode);
    pick = row[(3 - mode) * 11 +: 11];
  endfunction

  // The whole table is constant, so this folds into a small ROM.
  wire [43:0] row_sel;
  assign row_sel = (rate_in == 3'h0) ? `SWIC_OSR_800 :
                   (rate_in == 3'h1) ? `SWIC_OSR_400 :
                   (rate_in == 3'h2) ? `SWIC_OSR_200 :
                   (rate_in == 3'h3) ? `SWIC_OSR_100 :
                   (rate_in == 3'h4) ? `SWIC_OSR_50 :
                   (rate_in == 3'h5) ? `SWIC_OSR_12_5 :
                   (rate_in == 3'h6) ? `SWIC_OSR_6_25 :
                                       `SWIC_OSR_1_5625;
  assign ratio_out = pick(row_sel, mode_in);

endmodule // swic_osr_lookup

// file: testbench/swic_checker.sv
// Concurrent checks on the ports of the sleep/wake interrupt control block.
// Assumes one clock domain with a synchronous, active high reset.
`timescale 1ns/1ps
`include "swic_params.svh"
module swic_checker (
  input wire logic       clk_in, rst_in, reg_wr_in, sleep_mode_in, auto_sleep_en_in, // Clock, reset, strobes.
  input wire logic       sample_valid_in, fifo_empty_in, irq_one_req_in, irq_two_req_in, // Buffer and requests.
  input wire logic [7:0] reg_addr_in, reg_wdata_in, ctrl_out,                        // Register port.
  input wire logic [4:0] det_event_in, det_enable_out,                               // Detector events and enables.
  input wire logic       fifo_flush_out, fifo_accept_out, fifo_held_out, fifo_gate_err_out, // Gate outputs.
  input wire logic       debounce_clr_out, wake_req_out, irq_line_one_out, irq_line_two_oe_n_out // Misc outputs.
);
  logic sleep_q_reg; // Mode seen last cycle; resets to wake like the design's own copy.
  wire  chg = sleep_mode_in != sleep_q_reg; // A mode change in this cycle.
  // Track the previous mode so a change can be named without $past right after reset.
  always_ff @(posedge clk_in) sleep_q_reg <= rst_in ? 1'b0 : sleep_mode_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_reg; reg_wr_in && reg_addr_in == `SWIC_CTRL_ADDR |=> ctrl_out == $past(reg_wdata_in); endproperty
  a_reg: assert property (p_reg) else $error("control write lost");
  property p_flush; !ctrl_out[`SWIC_BIT_FIFO_GATE] && chg |=> fifo_flush_out; endproperty
  a_flush: assert property (p_flush) else $error("no flush on mode change");
  property p_hold; ctrl_out[7] && chg && !fifo_empty_in |=> fifo_held_out && !fifo_flush_out; endproperty
  a_hold: assert property (p_hold) else $error("buffer not held");
  property p_refuse; fifo_held_out && !fifo_empty_in |=> !fifo_accept_out; endproperty
  a_refuse: assert property (p_refuse) else $error("sample taken while held");
  property p_err_set; fifo_held_out && !fifo_empty_in && sample_valid_in |=> fifo_gate_err_out; endproperty
  a_err_set: assert property (p_err_set) else $error("gate error not raised");
  property p_err_clr; fifo_empty_in |=> !fifo_gate_err_out && !fifo_held_out; endproperty
  a_err_clr: assert property (p_err_clr) else $error("gate error not cleared");
  property p_den; !rst_in |=> det_enable_out == ({5{!$past(sleep_mode_in)}} | $past(ctrl_out[6:2])); endproperty
  a_den: assert property (p_den) else $error("detector enable wrong");
  property p_wake; !rst_in |=> wake_req_out == ($past(sleep_mode_in) && |($past(det_event_in & ctrl_out[6:2])));
  endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");
  property p_dbc; auto_sleep_en_in && chg |=> debounce_clr_out; endproperty
  a_dbc: assert property (p_dbc) else $error("debounce clear missing");
  property p_pin_one; !rst_in |=> irq_line_one_out ==
    (!$past(ctrl_out[0]) && ($past(ctrl_out[1]) ~^ $past(irq_one_req_in)));
  endproperty
  a_pin_one: assert property (p_pin_one) else $error("pin one value wrong");
  property p_pin_two; !rst_in |=> irq_line_two_oe_n_out ==
    ($past(ctrl_out[0]) && ($past(ctrl_out[1]) ~^ $past(irq_two_req_in)));
  endproperty
  a_pin_two: assert property (p_pin_two) else $error("pin two enable wrong");
endmodule // swic_checker
bind swic_top swic_checker chk_u (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
  .sleep_mode_in(sleep_mode_in), .auto_sleep_en_in(auto_sleep_en_in), .sample_valid_in(sample_valid_in),
  .fifo_empty_in(fifo_empty_in),
  .irq_one_req_in(irq_one_req_in), .irq_two_req_in(irq_two_req_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .ctrl_out(ctrl_out), .det_event_in(det_event_in), .det_enable_out(det_enable_out),
  .fifo_flush_out(fifo_flush_out), .fifo_accept_out(fifo_accept_out), .fifo_held_out(fifo_held_out),
  .fifo_gate_err_out(fifo_gate_err_out), .debounce_clr_out(debounce_clr_out), .wake_req_out(wake_req_out),
  .irq_line_one_out(irq_line_one_out), .irq_line_two_oe_n_out(irq_line_two_oe_n_out));

// file: testbench/swic_host_model.sv
// Model of the far side: the sample buffer the host empties, and the pulled-up interrupt wires.
// Assumes the same clock as the block and a one-cycle drain request from the bench.
`timescale 1ns/1ps
module swic_host_model (
  input  wire logic clk_in,      // System clock.
  input  wire logic rst_in,      // Synchronous reset.
  input  wire logic flush_in,    // Flush pulse from the block.
  input  wire logic accept_in,   // Sample write pulse from the block.
  input  wire logic drain_in,    // Host reads the buffer out completely.
  input  wire logic one_val_in,  // Pin one value.
  input  wire logic one_oe_n_in, // Pin one drive, low while driving.
  input  wire logic two_val_in,  // Pin two value.
  input  wire logic two_oe_n_in, // Pin two drive, low while driving.
  output logic      empty_out,   // Buffer is empty.
  output logic      pin_one_out, // Resolved level of wire one.
  output logic      pin_two_out  // Resolved level of wire two.
);
  logic [5:0] count_reg; // Samples held; the real buffer is deeper than any test needs.
  // A flush or a full drain both leave the buffer empty; drain is the host's only way out of a hold.
  always_ff @(posedge clk_in)
  begin
    if (rst_in || flush_in || drain_in) count_reg <= 6'h00;
    else if (accept_in) count_reg <= count_reg + 6'h01;
  end
  assign empty_out   = count_reg == 6'h00;
  // An undriven wire floats up to the external pull-up level.
  assign pin_one_out = one_oe_n_in ? 1'b1 : one_val_in;
  assign pin_two_out = two_oe_n_in ? 1'b1 : two_val_in;
endmodule // swic_host_model

// file: testbench/sleep_wake_irq_control_bench.sv
// Self-checking bench: register access, buffer gate, sleep enables, pins and ratio lookup.
// Assumes the host model closes the loop on buffer level and interrupt wires.
`timescale 1ns/1ps
`include "swic_params.svh"
module sleep_wake_irq_control_bench;
  logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, auto = 1'b0; // Drives.
  logic sample = 1'b0, drain = 1'b0, req = 1'b0, want;              // Buffer, request, expectation.
  logic [7:0] addr = 8'h00, wdata = 8'h00;                          // Register port drives.
  logic [4:0] ev = 5'h00;                                           // Detector events.
  logic [2:0] rate = 3'h0;                                          // Data-rate code.
  logic [1:0] mode = 2'h0;                                          // Oversampling mode.
  wire  [7:0] rdata, ctrl;                                          // Register outputs.
  wire  [4:0] den;                                                  // Detector enables.
  wire  [10:0] osr;                                                 // Ratio in use.
  wire  flush, accept, held, err, dbc, wake, p1, p1oe, p2, p2oe, lv1, lv2, pin1, pin2, empty; // Observed.
  int   bad_count = 0, total_checks = 0, cyc = 0;                   // Counters.
  always #2.5 clk_in = ~clk_in;
  swic_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .sleep_mode_in(sleep), .auto_sleep_en_in(auto), .sample_valid_in(sample),
    .fifo_empty_in(empty), .det_event_in(ev), .irq_one_req_in(req), .irq_two_req_in(req), .rate_in(rate),
    .osr_mode_in(mode), .irq_line_one_in(pin1), .irq_line_two_in(pin2), .ctrl_out(ctrl), .fifo_flush_out(flush),
    .fifo_accept_out(accept), .fifo_held_out(held), .fifo_gate_err_out(err), .det_enable_out(den),
    .debounce_clr_out(dbc), .wake_req_out(wake), .osr_ratio_out(osr), .irq_line_one_out(p1),
    .irq_line_one_oe_n_out(p1oe), .irq_line_two_out(p2), .irq_line_two_oe_n_out(p2oe),
    .irq_line_one_level_out(lv1), .irq_line_two_level_out(lv2));
  swic_host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .flush_in(flush), .accept_in(accept), .drain_in(drain),
    .one_val_in(p1), .one_oe_n_in(p1oe), .two_val_in(p2), .two_oe_n_in(p2oe), .empty_out(empty),
    .pin_one_out(pin1), .pin_two_out(pin2));
  // Moving off the edge by a fixed 1 ns keeps drives and samples clear of the flops' own updates.
  task step(input int n); repeat (n) @(posedge clk_in); #1; endtask
  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin $display("MISMATCH %0t %s", $time, msg); bad_count++; end
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] d); addr = a; wdata = d; wr = 1'b1; step(1); wr = 1'b0; endtask
  task reg_rd(input logic [7:0] a, input logic [7:0] e); addr = a; rd = 1'b1; step(1); rd = 1'b0;
    chk(rdata === e, "read data"); endtask
  task pulse_sample; sample = 1'b1; step(1); sample = 1'b0; endtask
  // Reset value, read back, and the unmapped neighbour 8'h2d that must neither alter nor return the register.
  task t_regs;
    reg_rd(`SWIC_CTRL_ADDR, `SWIC_CTRL_RESET);
    reg_wr(`SWIC_CTRL_ADDR, 8'ha5);
    chk(ctrl === 8'ha5, "control value");
    step(1);
    reg_wr(8'h2d, 8'h00);
    reg_rd(`SWIC_CTRL_ADDR, 8'ha5);
    step(1);
    reg_rd(8'h2d, 8'h00);
  endtask
  // Gate off: a mode change empties a loaded buffer and clears debounce counters.
  task t_flush;
    reg_wr(`SWIC_CTRL_ADDR, 8'h00); pulse_sample(); step(1);
    chk(empty === 1'b0, "sample not stored");
    auto = 1'b1; sleep = 1'b1; step(1);
    chk(flush === 1'b1, "no flush");
    chk(dbc === 1'b1, "no debounce clear");
    step(1); chk(empty === 1'b1, "buffer kept");
  endtask
  // Gate on: change while loaded holds the buffer, a late sample raises the error until drained.
  task t_gate;
    reg_wr(`SWIC_CTRL_ADDR, 8'h80); pulse_sample(); step(1);
    sleep = 1'b0; step(1);
    chk(held === 1'b1 && flush === 1'b0, "not held");
    pulse_sample();
    chk(err === 1'b1 && accept === 1'b0, "late sample");
    step(1); chk(err === 1'b1 && empty === 1'b0, "error dropped");
    drain = 1'b1; step(1); drain = 1'b0; step(1);
    chk(err === 1'b0 && held === 1'b0, "hold not released");
  endtask
  // Each wake bit alone keeps its own detector alive in sleep; wake returns everything.
  task t_wake;
    sleep = 1'b1; ev = 5'h1f;
    for (int i = 0; i < 5; i++) begin
      reg_wr(`SWIC_CTRL_ADDR, 8'h04 << i); step(1);
      chk(den === (5'h01 << i) && wake === 1'b1, "sleep enable");
    end
    reg_wr(`SWIC_CTRL_ADDR, 8'h00); step(1);
    chk(den === 5'h00 && wake === 1'b0, "not suspended");
    sleep = 1'b0; step(2); chk(den === 5'h1f, "not resumed");
  endtask
  // All polarity and drive settings with both request levels, seen on the resolved wires.
  task t_pins;
    for (int c = 0; c < 4; c++) for (int r = 0; r < 2; r++) begin
      reg_wr(`SWIC_CTRL_ADDR, 8'(c)); req = r[0]; step(1); want = c[1] ? r[0] : !r[0];
      chk(pin1 === want && pin2 === want, "pin level");
      chk(p1oe === (c[0] & want), "pin drive");
      step(2); chk(lv1 === want && lv2 === want, "sensed level");
    end
  endtask
  // Fastest rate gives 2 in every mode; high resolution walks every rate code up to 1024 at the slowest.
  task t_osr;
    logic [10:0] hires [8]; // High-resolution ratio per rate code, fastest first; 4 at 400 Hz by choice.
    hires = '{11'h0002, 11'h0004, 11'h0008, 11'h0010, 11'h0020, 11'h0080, 11'h0100, 11'h0400};
    for (int m = 0; m < 4; m++) begin mode = m[1:0]; step(1); chk(osr === 11'h0002, "fast ratio"); end
    mode = 2'h2;
    for (int r = 1; r < 7; r++) begin rate = r[2:0]; step(1); chk(osr === hires[r], "rate ratio"); end
    rate = 3'h7; mode = 2'h2; step(1); chk(osr === 11'h0400, "slow ratio");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The scenarios need about a hundred cycles; thirty times that means a hang.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000) begin bad_count++; test_done(); end
  end
  initial
  begin
    step(20); rst_in = 1'b0; step(1);
    t_regs(); t_flush(); t_gate(); t_wake(); t_pins(); t_osr();
    test_done();
  end
endmodule // sleep_wake_irq_control_bench
